// >>> src/alias_remap.sv
`timescale 1ns/100ps
// How it works
// - per slot 7-bit physical address, resets zero
// - alias hit forwards with physical address substituted
// - per slot 7-bit alias compared with target
// - zero alias disables its slot
// - alias n maps to physical register n
// - auto-ack bit acknowledges writes locally
module alias_remap #(
    parameter int NUM_SLOTS = alias_remap_pkg::NUM_SLOTS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic req_valid,
    input wire logic [6:0] req_addr,
    input wire logic req_write,
    output logic req_ready,
    output logic fwd_valid,
    output logic [6:0] fwd_addr,
    output logic fwd_write,
    output logic [$clog2(NUM_SLOTS)-1:0] fwd_slot,
    input wire logic link_lock,
    input wire logic rsp_valid,
    input wire logic rsp_ack,
    output logic done_valid,
    output logic done_ack,
    output logic done_miss
);
    import alias_remap_pkg::*;

    localparam int SLOT_W = $clog2(NUM_SLOTS);

    typedef struct packed {
        remap_state_type state;
        logic ready;
        logic ack;
        logic [7:0] rdata;
        logic fwd_valid;
        logic [6:0] fwd_addr;
        logic fwd_write;
        logic [SLOT_W-1:0] fwd_slot;
        logic done_valid;
        logic done_ack;
        logic done_miss;
        logic last_hit;
        logic [SLOT_W-1:0] last_slot;
    } remap_regs_type;

    remap_regs_type remap_reg;
    remap_regs_type remap_next;

    logic [7:0] word_idx;
    logic bus_write;
    logic [NUM_SLOTS-1:0] phys_we;
    logic [NUM_SLOTS-1:0] alias_we;
    logic [NUM_SLOTS-1:0] hit_vec;
    logic [NUM_SLOTS-1:0] auto_vec;
    logic [7:0] phys_arr [NUM_SLOTS];
    logic [7:0] alias_arr [NUM_SLOTS];
    logic any_hit;
    logic [SLOT_W-1:0] hit_idx;
    logic [6:0] sel_phys;
    logic sel_auto;
    logic [7:0] rd_mux;
    logic accept;

    assign word_idx = wb_adr_i[9:2];
    // writes land on the edge where the master sees ack
    assign bus_write = wb_cyc_i && wb_stb_i && wb_we_i && remap_reg.ack &&
        wb_sel_i[0];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            assign phys_we[gi] = bus_write &&
                word_idx == PHYS_BASE_IDX + 8'(gi);
            assign alias_we[gi] = bus_write &&
                word_idx == ALIAS_BASE_IDX + 8'(gi);
            alias_slot u_slot (
                .clk(clk),
                .rst(rst),
                .ce(ce),
                .phys_we(phys_we[gi]),
                .alias_we(alias_we[gi]),
                .wdata(wb_dat_i[7:0]),
                .cmp_addr(req_addr),
                .phys_q(phys_arr[gi]),
                .alias_q(alias_arr[gi]),
                .hit(hit_vec[gi]),
                .auto_ack(auto_vec[gi])
            );
        end
    endgenerate

    // lowest matching slot wins; the same index picks the physical register
    always_comb begin
        any_hit = 1'h0;
        hit_idx = '0;
        for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                any_hit = 1'h1;
                hit_idx = SLOT_W'(i);
            end
        end
        sel_phys = phys_arr[hit_idx][ADDR_MSB:ADDR_LSB];
        sel_auto = auto_vec[hit_idx];
    end

    // read data; unmapped words read zero
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (word_idx == PHYS_BASE_IDX + 8'(i)) begin
                rd_mux = phys_arr[i];
            end
            if (word_idx == ALIAS_BASE_IDX + 8'(i)) begin
                rd_mux = alias_arr[i];
            end
        end
        if (word_idx == REMAP_STATUS_IDX) begin
            rd_mux = 8'h00;
            rd_mux[SLOT_W-1:0] = remap_reg.last_slot;
            rd_mux[6] = remap_reg.last_hit;
            rd_mux[7] = !remap_reg.ready;
        end
    end

    assign accept = req_valid && remap_reg.ready;

    always_comb begin
        remap_next = remap_reg;
        remap_next.fwd_valid = 1'h0;
        remap_next.done_valid = 1'h0;
        remap_next.done_ack = 1'h0;
        remap_next.done_miss = 1'h0;
        remap_next.ack = wb_cyc_i && wb_stb_i && !remap_reg.ack;
        if (wb_cyc_i && wb_stb_i && !remap_reg.ack) begin
            remap_next.rdata = rd_mux;
        end
        unique case (remap_reg.state)
            ST_IDLE: begin
                if (accept && any_hit) begin
                    remap_next.fwd_valid = 1'h1;
                    remap_next.fwd_addr = sel_phys;
                    remap_next.fwd_write = req_write;
                    remap_next.fwd_slot = hit_idx;
                    remap_next.last_hit = 1'h1;
                    remap_next.last_slot = hit_idx;
                    if (req_write && sel_auto) begin
                        remap_next.done_valid = 1'h1;
                        remap_next.done_ack = 1'h1;
                    end else begin
                        remap_next.state = ST_WAIT;
                    end
                end else if (accept) begin
                    remap_next.done_valid = 1'h1;
                    remap_next.done_miss = 1'h1;
                    remap_next.last_hit = 1'h0;
                end
            end
            ST_WAIT: begin
                if (rsp_valid) begin
                    remap_next.done_valid = 1'h1;
                    remap_next.done_ack = rsp_ack && link_lock;
                    remap_next.state = ST_IDLE;
                end
            end
            default: begin
                remap_next.state = ST_IDLE;
            end
        endcase
        remap_next.ready = remap_next.state == ST_IDLE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            remap_reg <= '0;
            remap_reg.state <= ST_IDLE;
            remap_reg.ready <= 1'h1;
        end else if (ce) begin
            remap_reg <= remap_next;
        end
    end

    assign wb_dat_o = {24'h000000, remap_reg.rdata};
    assign wb_ack_o = remap_reg.ack;
    assign req_ready = remap_reg.ready;
    assign fwd_valid = remap_reg.fwd_valid;
    assign fwd_addr = remap_reg.fwd_addr;
    assign fwd_write = remap_reg.fwd_write;
    assign fwd_slot = remap_reg.fwd_slot;
    assign done_valid = remap_reg.done_valid;
    assign done_ack = remap_reg.done_ack;
    assign done_miss = remap_reg.done_miss;

    property p_remap_addr;
        @(posedge clk) disable iff (rst)
        ce && accept && any_hit |=>
            fwd_valid && fwd_addr == $past(sel_phys);
    endproperty
    a_remap_addr: assert property (p_remap_addr)
        else $error("forwarded address is not the physical address");

    property p_pairing;
        @(posedge clk) disable iff (rst)
        ce && accept && any_hit |=> fwd_slot == $past(hit_idx);
    endproperty
    a_pairing: assert property (p_pairing)
        else $error("forwarded slot differs from matching alias");

    property p_miss;
        @(posedge clk) disable iff (rst)
        ce && accept && !any_hit |=> done_valid && done_miss && !fwd_valid;
    endproperty
    a_miss: assert property (p_miss)
        else $error("unmatched address was forwarded");

    property p_auto_ack;
        @(posedge clk) disable iff (rst)
        ce && accept && any_hit && req_write && sel_auto |=>
            done_valid && done_ack && req_ready;
    endproperty
    a_auto_ack: assert property (p_auto_ack)
        else $error("auto-acknowledged write not answered at once");

    property p_no_auto;
        @(posedge clk) disable iff (rst)
        ce && accept && any_hit && !(req_write && sel_auto) |=>
            !done_valid && !req_ready;
    endproperty
    a_no_auto: assert property (p_no_auto)
        else $error("write acknowledged without auto-ack");

    property p_wait_rsp;
        @(posedge clk) disable iff (rst)
        ce && !req_ready && rsp_valid |=>
            done_valid && done_ack == ($past(rsp_ack) && $past(link_lock));
    endproperty
    a_wait_rsp: assert property (p_wait_rsp)
        else $error("remote answer not passed back");

    property p_bus_ack;
        @(posedge clk) disable iff (rst)
        ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("bus ack not a single cycle after request");
endmodule

// >>> src/alias_remap_pkg.sv
package alias_remap_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] REMOTE_PHYS_ADDR_6_IDX = 8'h3F;
    localparam logic [7:0] REMOTE_PHYS_ADDR_7_IDX = 8'h40;
    localparam logic [7:0] REMOTE_ALIAS_SLOT_0_IDX = 8'h41;
    localparam logic [7:0] REMOTE_ALIAS_SLOT_1_IDX = 8'h42;
    localparam logic [7:0] REMOTE_ALIAS_SLOT_2_IDX = 8'h43;
    localparam logic [7:0] REMOTE_ALIAS_SLOT_3_IDX = 8'h44;
    localparam logic [7:0] PHYS_SLOT_6 = 8'h06;
    localparam logic [7:0] PHYS_BASE_IDX = REMOTE_PHYS_ADDR_6_IDX - PHYS_SLOT_6;
    localparam logic [7:0] ALIAS_BASE_IDX = REMOTE_ALIAS_SLOT_0_IDX;
    localparam logic [7:0] REMAP_STATUS_IDX = 8'h60;

    // field layout
    localparam int ADDR_MSB = 7;
    localparam int ADDR_LSB = 1;
    localparam int AUTO_ACK_BIT = 0;

    // reset values
    localparam logic [6:0] PHYS_RESET = 7'h00;
    localparam logic [6:0] ALIAS_RESET = 7'h00;
    localparam logic AUTO_ACK_RESET = 1'h0;
    localparam logic [6:0] ALIAS_DISABLED = 7'h00;

    localparam int NUM_SLOTS = 8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01
    } remap_state_type;

endpackage

// >>> src/alias_slot.sv
`timescale 1ns/100ps
module alias_slot (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic phys_we,
    input wire logic alias_we,
    input wire logic [7:0] wdata,
    input wire logic [6:0] cmp_addr,
    output logic [7:0] phys_q,
    output logic [7:0] alias_q,
    output logic hit,
    output logic auto_ack
);
    import alias_remap_pkg::*;

    typedef struct packed {
        logic [6:0] phys;
        logic [6:0] alias_id;
        logic auto_ack;
    } slot_state_type;

    slot_state_type slot_reg;
    slot_state_type slot_next;

    always_comb begin
        slot_next = slot_reg;
        if (phys_we) begin
            slot_next.phys = wdata[ADDR_MSB:ADDR_LSB];
        end
        if (alias_we) begin
            slot_next.alias_id = wdata[ADDR_MSB:ADDR_LSB];
            slot_next.auto_ack = wdata[AUTO_ACK_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            slot_reg <= '{PHYS_RESET, ALIAS_RESET, AUTO_ACK_RESET};
        end else if (ce) begin
            slot_reg <= slot_next;
        end
    end

    assign phys_q = {slot_reg.phys, 1'h0};
    assign alias_q = {slot_reg.alias_id, slot_reg.auto_ack};
    assign auto_ack = slot_reg.auto_ack;
    // a zero alias never matches
    assign hit = (slot_reg.alias_id != ALIAS_DISABLED) &&
        (slot_reg.alias_id == cmp_addr);

    property p_phys_write;
        @(posedge clk) disable iff (rst)
        ce && phys_we |=> phys_q == {$past(wdata[7:1]), 1'h0};
    endproperty
    a_phys_write: assert property (p_phys_write)
        else $error("physical address write not stored");

    property p_disabled;
        @(posedge clk) disable iff (rst)
        ce && alias_we && wdata[7:1] == 7'h00 |=> !hit [*2];
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("zero alias produced a match");
endmodule

// >>> test/remote_model.sv
`timescale 1ns/100ps
module remote_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic fwd_valid,
    input wire logic [3:0] delay,
    input wire logic nak,
    output logic rsp_valid,
    output logic rsp_ack,
    output logic busy
);
    logic [3:0] cnt_reg;
    // answer each forwarded request after a chosen delay
    // outside an answer the ack line toggles, so it is never trusted alone
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'h0;
            rsp_valid <= 1'h0;
            rsp_ack <= 1'h0;
            cnt_reg <= 4'h0;
        end else if (fwd_valid) begin
            busy <= 1'h1;
            rsp_valid <= 1'h0;
            rsp_ack <= ~rsp_ack;
            cnt_reg <= delay;
        end else if (busy && cnt_reg == 4'h0) begin
            busy <= 1'h0;
            rsp_valid <= 1'h1;
            rsp_ack <= ~nak;
        end else begin
            rsp_valid <= 1'h0;
            rsp_ack <= ~rsp_ack;
            if (busy) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
    import alias_remap_pkg::*;
    logic clk, rst, cyc, stb, we, ack, rq_v, rq_w, rdy, ak;
    logic fv, fw, dv, da, dm, lock, rv, ra, busy, nak;
    logic [9:0] adr;
    logic [31:0] wd, rd_o, rd;
    logic [6:0] rq_a, fa;
    logic [2:0] fs;
    logic [3:0] dly;
    logic [7:0] rnd;
    logic [7:0] pv [8];
    int n_errors, checks;
    alias_remap #(.NUM_SLOTS(8)) dut (.clk(clk), .rst(rst), .ce(1'h1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd_o), .wb_ack_o(ack),
        .req_valid(rq_v), .req_addr(rq_a), .req_write(rq_w),
        .req_ready(rdy), .fwd_valid(fv), .fwd_addr(fa), .fwd_write(fw),
        .fwd_slot(fs), .link_lock(lock), .rsp_valid(rv), .rsp_ack(ra),
        .done_valid(dv), .done_ack(da), .done_miss(dm));
    remote_model far (.clk(clk), .rst(rst), .fwd_valid(fv), .delay(dly),
        .nak(nak), .rsp_valid(rv), .rsp_ack(ra), .busy(busy));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] rb(input logic [7:0] v, input logic p);
        return {24'h000000, v[7:1], v[0] & ~p};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d, errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {idx, 2'h0};
        wd <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'h1) @(posedge clk);
        rd = rd_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wrd(input logic [7:0] idx, input logic [7:0] d,
                       input logic p);
        wb(1'h1, idx, d);
        wb(1'h0, idx, 8'h00);
        check(rd, rb(d, p));
    endtask
    task automatic req(input logic [6:0] a, input logic w, input logic hit,
                       input int s, input logic k_ack, input logic same);
        int fc, dc, k, bz;
        logic seen;
        seen = 1'h0;
        fc = 0;
        dc = 0;
        bz = 0;
        while (busy) @(posedge clk);
        rq_v <= 1'h1;
        rq_a <= a;
        rq_w <= w;
        @(posedge clk);
        while (rdy !== 1'h1) @(posedge clk);
        rq_v <= 1'h0;
        for (k = 1; k < 40 && dc == 0; k++) begin
            @(posedge clk);
            if (fv === 1'h1) begin
                seen = 1'h1;
                fc = k;
            end
            if (dv === 1'h1) dc = k;
            if (rdy === 1'h0) bz++;
        end
        check(seen, hit);
        check(dm, !hit);
        check(bz, dc - 1);
        check(da, k_ack);
        if (hit) begin
            check(fa, pv[s][7:1]);
            check(fs, s[2:0]);
            check(fw, w);
            check(fc == dc, same);
        end
    endtask
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        final_report;
    end
    initial begin
        rst = 1'h1;
        {cyc, stb, we, rq_v, rq_w, lock, nak} = 7'h00;
        adr = 10'h000;
        wd = 32'h0;
        rq_a = 7'h00;
        dly = 4'h0;
        rnd = 8'h1F;
        n_errors = 0;
        checks = 0;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            wb(1'h0, REMOTE_PHYS_ADDR_6_IDX + 8'(i), 8'h00);
            check(rd, 32'h0);
        end
        wb(1'h0, 8'h70, 8'h00);
        check(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            pv[i] = rnd | 8'h01;
            wrd(PHYS_BASE_IDX + 8'(i), pv[i], 1'h1);
            wrd(ALIAS_BASE_IDX + 8'(i), {7'h10 + 7'(i), 1'h0}, 1'h0);
        end
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            dly <= rnd[3:0];
            nak <= rnd[4];
            lock <= rnd[5];
            ak = rnd[5] & ~rnd[4];
            req(7'h10 + 7'(i), rnd[6], 1'h1, i, ak, 1'h0);
        end
        lock <= 1'h0;
        nak <= 1'h1;
        wrd(ALIAS_BASE_IDX + 8'h02, 8'h25, 1'h0);
        req(7'h12, 1'h1, 1'h1, 2, 1'h1, 1'h1);
        wb(1'h0, REMAP_STATUS_IDX, 8'h00);
        check(rd, 32'h42);
        req(7'h12, 1'h0, 1'h1, 2, 1'h0, 1'h0);
        wrd(ALIAS_BASE_IDX + 8'h02, 8'h24, 1'h0);
        req(7'h12, 1'h1, 1'h1, 2, 1'h0, 1'h0);
        wrd(ALIAS_BASE_IDX + 8'h03, 8'h00, 1'h0);
        req(7'h13, 1'h1, 1'h0, 3, 1'h0, 1'h0);
        req(7'h00, 1'h0, 1'h0, 0, 1'h0, 1'h0);
        req(7'h7F, 1'h0, 1'h0, 0, 1'h0, 1'h0);
        final_report;
    end
endmodule
